// ==== core/mute_override_map.vh ====
// Constants for the mute-dependent override controller: config bits,
// register offsets and reset values, and the timing figures in their own units.
// Assumes a 125 MHz core clock.
//
// Functional notes
// - Mute time limit resets to ten minutes.
// - One override pin allows only pulse pattern.
// - Override needs zone violated, output off, sensor.
// - Pulse pattern: three short openings under one second.
// - Accepted override lights display and green indicator.
// - Two pins allow pulse, level or edge modes.
// - Override forces only the muted output pair.
// - Forced pair stays on despite outside blockage.
// - Input 1 leads input 2 by 120-400 ms.
// - Override ends after 120 seconds.
// - Bidirectional: end on zone clear or sensors off.
// - Level mode: end when either input idles.
// - Unidirectional: end when sensors off and zone clear.
// - Auto restart keeps outputs on after clear end.
// - Pulse and edge modes ignore inputs after start.
// - Direction selects bi/unidirectional, default bidirectional.
// - Total or partial muting selectable.
// - Unidirectional mute starts when sensors within delay.
// - Unidirectional mute ends factor times interval after clear.
// - Two-pin: input 1 normally open, input 2 closed.
// - Mute limit 10..1080 minutes, zero unlimited.
`ifndef MUTE_OVERRIDE_MAP_VH
`define MUTE_OVERRIDE_MAP_VH

// Register byte offsets
`define REG_CONFIG 12'h000
`define REG_MUTE_LIMIT 12'h004
`define REG_ACT_DELAY 12'h008
`define REG_EXT_FACTOR 12'h00C
`define REG_STATUS 12'h010

// Config field positions
`define CFG_MODE_LSB 0
`define CFG_TWO_PINS 2
`define CFG_UNIDIR 3
`define CFG_PARTIAL 4
`define CFG_AUTO_RESTART 5
`define CFG_PAIR_SEL 6

// Override start modes
`define MODE_PULSE 2'h0
`define MODE_LEVEL 2'h1
`define MODE_EDGE 2'h2

// Reset values
`define CONFIG_RESET 7'h00
`define MUTE_LIMIT_RESET 11'h00A
`define MUTE_LIMIT_MIN 11'h00A
`define MUTE_LIMIT_MAX 11'h438
`define ACT_DELAY_RESET 16'h0BB8
`define EXT_FACTOR_RESET 4'h2

// Times in their own units
`define CLK_MHZ 125
`define TICK_US 1000
`define PULSE_OPEN_MAX_MS 1000
`define LEAD_MIN_MS 120
`define LEAD_MAX_MS 400
`define OVR_MAX_S 120
`define PULSE_COUNT 3
`define MS_PER_MIN 60000

`endif

// ==== core/ms_tick.v ====
// Millisecond tick generator: one-cycle pulse every TICK_CYCLES clocks.
// Assumes a free-running core clock.
`timescale 1ns/1ps

module ms_tick #(
	parameter TICK_CYCLES = 125000
) (
	input wire core_clk, // Core clock
	input wire rst, // Async reset, active high
	output reg tick // One-cycle pulse
);
	reg [16:0] cnt_q;

	// ============================================================
	// Divider
	// Free-running so every interval shares one time base
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 17'h00000;
			tick <= 1'b0;
		end else if (cnt_q == TICK_CYCLES - 1) begin
			cnt_q <= 17'h00000;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 17'h00001;
			tick <= 1'b0;
		end
	end
endmodule // ms_tick

// ==== core/sync2.v ====
// Two-flop synchroniser for an asynchronous level input.
// Assumes input changes slower than the core clock.
`timescale 1ns/1ps

module sync2 #(
	parameter RESET_VAL = 1'b0
) (
	input wire core_clk, // Core clock
	input wire rst, // Async reset
	input wire din, // Asynchronous level
	output reg dout // Synchronised level
);
	reg meta_q;

	// ============================================================
	// Stages; only the second flop reads the first
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_q <= RESET_VAL;
			dout <= RESET_VAL;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule // sync2

// ==== core/mute_override_ctrl.v ====
// Mute-dependent override and unidirectional muting controller.
// Assumes APB3 master on core_clk; pins are asynchronous and synchronised here.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "mute_override_map.vh"

module mute_override_ctrl #(
	parameter TICK_CYCLES = 125000
) (
	input wire core_clk, // 125 MHz clock
	input wire rst, // Async reset, high
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [11:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error
	input wire bypassIn1, // Override pin 1 (pulse pin)
	input wire bypassIn2, // Override pin 2
	input wire firstMuteSensor, // Mute sensor 1, high active
	input wire secondMuteSensor, // Mute sensor 2, high active
	input wire zoneViolated, // Muted zone violated
	input wire sectionViolated, // Partial-mute section violated
	input wire otherZoneViolated, // Zone of the other pair violated
	output reg safetyOutputPairA, // Pair A on
	output reg safetyOutputPairB, // Pair B on
	output reg overrideDisplay, // Display shows override
	output reg indicatorGreen, // Output indicator green
	output reg muteActive // Muting in progress
);
	localparam [16:0] TICK_W = TICK_CYCLES;
	localparam [10:0] PULSE_MAX = `PULSE_OPEN_MAX_MS * 1000 / `TICK_US;
	localparam [10:0] LEAD_MIN = `LEAD_MIN_MS * 1000 / `TICK_US;
	localparam [10:0] LEAD_MAX = `LEAD_MAX_MS * 1000 / `TICK_US;
	localparam [16:0] OVR_MAX = `OVR_MAX_S * 1000 * 1000 / `TICK_US;
	localparam [1:0] OV_IDLE = 2'h0;
	localparam [1:0] OV_LEAD = 2'h1;
	localparam [1:0] OV_ON = 2'h2;
	localparam [1:0] MU_IDLE = 2'h0;
	localparam [1:0] MU_WAIT = 2'h1;
	localparam [1:0] MU_ON = 2'h2;
	localparam [1:0] MU_TAIL = 2'h3;

	// ============================================================
	// Synchronisers and tick
	wire b1S, b2S, m1S, m2S, zoneS, secS, otherS, tick;
	sync2 #(.RESET_VAL(1'b1)) uB1 (.core_clk(core_clk), .rst(rst), .din(bypassIn1), .dout(b1S));
	sync2 #(.RESET_VAL(1'b1)) uB2 (.core_clk(core_clk), .rst(rst), .din(bypassIn2), .dout(b2S));
	sync2 uM1 (.core_clk(core_clk), .rst(rst), .din(firstMuteSensor), .dout(m1S));
	sync2 uM2 (.core_clk(core_clk), .rst(rst), .din(secondMuteSensor), .dout(m2S));
	sync2 uZn (.core_clk(core_clk), .rst(rst), .din(zoneViolated), .dout(zoneS));
	sync2 uSc (.core_clk(core_clk), .rst(rst), .din(sectionViolated), .dout(secS));
	sync2 uOt (.core_clk(core_clk), .rst(rst), .din(otherZoneViolated), .dout(otherS));
	ms_tick #(.TICK_CYCLES(TICK_W)) uTick (.core_clk(core_clk), .rst(rst), .tick(tick));

	// ============================================================
	// Configuration registers
	reg [6:0] config_q;
	reg [10:0] muteLimit_q;
	reg [15:0] actDelay_q;
	reg [3:0] extFactor_q;
	wire apbAcc = psel & penable;
	wire apbWr = apbAcc & pwrite;
	wire [1:0] cfgMode = config_q[`CFG_MODE_LSB+1:`CFG_MODE_LSB];
	wire twoPins = config_q[`CFG_TWO_PINS];
	wire unidir = config_q[`CFG_UNIDIR]; // Reset clear: bidirectional
	wire partial = config_q[`CFG_PARTIAL]; // Total or partial muting
	wire autoRestart = config_q[`CFG_AUTO_RESTART];
	wire pairSel = config_q[`CFG_PAIR_SEL];
	// Single pin leaves only the pulse pattern; three modes with two pins
	wire [1:0] mode = (twoPins && cfgMode != 2'h3) ? cfgMode : `MODE_PULSE;
	wire [10:0] limWr = pwdata[10:0];
	wire limOk = (limWr == 11'h000) ||
		(limWr >= `MUTE_LIMIT_MIN && limWr <= `MUTE_LIMIT_MAX);
	wire addrOk = (paddr == `REG_CONFIG) || (paddr == `REG_MUTE_LIMIT) ||
		(paddr == `REG_ACT_DELAY) || (paddr == `REG_EXT_FACTOR) || (paddr == `REG_STATUS);

	// Writes take effect in the access cycle; out-of-range limits are refused
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			config_q <= `CONFIG_RESET;
			muteLimit_q <= `MUTE_LIMIT_RESET; // Ten minutes out of reset
			actDelay_q <= `ACT_DELAY_RESET;
			extFactor_q <= `EXT_FACTOR_RESET;
		end else if (apbWr) begin
			case (paddr)
				`REG_CONFIG: config_q <= pwdata[6:0];
				`REG_MUTE_LIMIT: if (limOk) muteLimit_q <= limWr;
				`REG_ACT_DELAY: actDelay_q <= pwdata[15:0];
				`REG_EXT_FACTOR: extFactor_q <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	// ============================================================
	// Muting sequencer
	reg [1:0] muState_q;
	reg [15:0] muCnt_q; // Activation interval in ms
	reg [19:0] tailCnt_q;
	reg [19:0] tailLim_q;
	reg [16:0] limMs_q;
	reg [10:0] limMin_q;
	wire anySens = m1S | m2S;
	wire bothSens = m1S & m2S;
	wire limHit = (muteLimit_q != 11'h000) && (limMin_q >= muteLimit_q);

	// Both sensors made within the delay start muting in either order
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			muState_q <= MU_IDLE;
			muCnt_q <= 16'h0000;
			tailCnt_q <= 20'h00000;
			tailLim_q <= 20'h00000;
			limMs_q <= 17'h00000;
			limMin_q <= 11'h000;
		end else begin
			case (muState_q)
				MU_IDLE: begin
					muCnt_q <= 16'h0000;
					limMs_q <= 17'h00000;
					limMin_q <= 11'h000;
					if (bothSens) muState_q <= MU_ON;
					else if (anySens) muState_q <= MU_WAIT;
				end
				MU_WAIT: begin
					if (!anySens) muState_q <= MU_IDLE;
					else if (bothSens) begin
						muState_q <= MU_ON;
						tailLim_q <= muCnt_q * extFactor_q;
					end else if (tick) begin
						if (muCnt_q >= actDelay_q) muState_q <= MU_IDLE;
						else muCnt_q <= muCnt_q + 16'h0001;
					end
				end
				MU_ON, MU_TAIL: begin
					// Mute time limit ends muting whatever the sensors say
					if (tick) begin
						if (limMs_q == `MS_PER_MIN - 1) begin
							limMs_q <= 17'h00000;
							limMin_q <= limMin_q + 11'h001;
						end else limMs_q <= limMs_q + 17'h00001;
					end
					if (limHit) muState_q <= MU_IDLE;
					else if (muState_q == MU_ON) begin
						tailCnt_q <= 20'h00000;
						if (unidir && !bothSens) muState_q <= MU_TAIL;
						else if (!unidir && !bothSens) muState_q <= MU_IDLE;
					end else begin
						if (tick) tailCnt_q <= tailCnt_q + 20'h00001;
						if (tailCnt_q >= tailLim_q) muState_q <= MU_IDLE;
					end
				end
				default: muState_q <= MU_IDLE;
			endcase
		end
	end
	wire muting = (muState_q == MU_ON) || (muState_q == MU_TAIL);
	// Partial muting only suspends the section, rest of zone still counts
	wire zoneBlocks = muting ? (partial & zoneS & ~secS) : zoneS;

	// ============================================================
	// Override sequencer
	reg [1:0] ovState_q;
	reg [1:0] pulses_q;
	reg [10:0] phCnt_q;
	reg [16:0] ovCnt_q;
	reg [1:0] mOut_q; // Muted pair, other pair
	reg b1Prev_q;
	wire pairOff = ~mOut_q[0];
	// Request honoured only with zone violated, pair off, a sensor on
	wire armed = zoneS & pairOff & anySens;
	wire ovOn = (ovState_q == OV_ON);
	// Natural end conditions of an active override
	wire endBi = ~unidir & (~zoneS | ~anySens);
	wire endUni = unidir & ~anySens & ~zoneS;
	wire endLvl = (mode == `MODE_LEVEL) & (~b1S | b2S);
	wire endTime = tick & (ovCnt_q >= OVR_MAX - 17'h00001);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ovState_q <= OV_IDLE;
			pulses_q <= 2'h0;
			phCnt_q <= 11'h000;
			ovCnt_q <= 17'h00000;
			b1Prev_q <= 1'b1;
		end else begin
			b1Prev_q <= b1S;
			case (ovState_q)
				OV_IDLE: begin
					ovCnt_q <= 17'h00000;
					if (!armed) begin
						pulses_q <= 2'h0;
						phCnt_q <= 11'h000;
					end else if (mode == `MODE_PULSE) begin
						// Each opening of the closed switch must be under a second
						if (!b1S) begin
							if (tick) phCnt_q <= phCnt_q + 11'h001;
							if (phCnt_q >= PULSE_MAX) pulses_q <= 2'h0;
						end else if (!b1Prev_q) begin
							phCnt_q <= 11'h000;
							if (phCnt_q < PULSE_MAX) begin
								if (pulses_q == `PULSE_COUNT - 1) ovState_q <= OV_ON;
								else pulses_q <= pulses_q + 2'h1;
							end
						end
					end else if (b1S && !b1Prev_q && b2S) begin
						// Input 1 rose from normally open idle
						phCnt_q <= 11'h000;
						ovState_q <= OV_LEAD;
					end
				end
				OV_LEAD: begin
					// Input 2 must drop 120 to 400 ms after input 1 rose
					if (tick) phCnt_q <= phCnt_q + 11'h001;
					if (!armed || !b1S) ovState_q <= OV_IDLE;
					else if (!b2S) ovState_q <= (phCnt_q >= LEAD_MIN) ? OV_ON : OV_IDLE;
					else if (phCnt_q > LEAD_MAX) ovState_q <= OV_IDLE;
				end
				OV_ON: begin
					pulses_q <= 2'h0;
					phCnt_q <= 11'h000;
					if (tick) ovCnt_q <= ovCnt_q + 17'h00001;
					// Pulse and edge modes never look at the pins here
					if (endTime || endBi || endUni || endLvl) ovState_q <= OV_IDLE;
				end
				default: ovState_q <= OV_IDLE;
			endcase
		end
	end

	// ============================================================
	// Safety outputs and indication
	// Forced pair ignores blockage; the other pair follows its own zone
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mOut_q <= 2'b00;
			safetyOutputPairA <= 1'b0;
			safetyOutputPairB <= 1'b0;
			overrideDisplay <= 1'b0;
			indicatorGreen <= 1'b0;
			muteActive <= 1'b0;
		end else begin
			if (ovOn) mOut_q[0] <= 1'b1;
			else if (zoneBlocks) mOut_q[0] <= 1'b0;
			else if (autoRestart) mOut_q[0] <= 1'b1; // Stays on after clear end
			mOut_q[1] <= ~otherS;
			safetyOutputPairA <= pairSel ? mOut_q[1] : mOut_q[0];
			safetyOutputPairB <= pairSel ? mOut_q[0] : mOut_q[1];
			overrideDisplay <= ovOn;
			indicatorGreen <= mOut_q[0];
			muteActive <= muting;
		end
	end

	// ============================================================
	// APB read path, zero wait states
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~addrOk;
			prdata <= 32'h00000000;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`REG_CONFIG: prdata <= {25'h0000000, config_q};
					`REG_MUTE_LIMIT: prdata <= {21'h000000, muteLimit_q};
					`REG_ACT_DELAY: prdata <= {16'h0000, actDelay_q};
					`REG_EXT_FACTOR: prdata <= {28'h0000000, extFactor_q};
					`REG_STATUS: prdata <= {22'h000000, limHit, muState_q, ovState_q,
						pulses_q, mOut_q, ovOn};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // mute_override_ctrl

// ==== verif/mute_override_sva.sv ====
// Port-level assertions for the override controller.
// Assumes it is bound to mute_override_ctrl and sees only its ports.
`timescale 1ns/1ps
module mute_override_sva #(
	parameter TICK_CYCLES = 125000
) (
	input wire core_clk, // Clock
	input wire rst, // Reset, high
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pready, // APB ready
	input wire pslverr, // APB error
	input wire firstMuteSensor, // Sensor 1
	input wire secondMuteSensor, // Sensor 2
	input wire zoneViolated, // Muted zone
	input wire otherZoneViolated, // Other zone
	input wire safetyOutputPairA, // Pair A
	input wire safetyOutputPairB, // Pair B
	input wire overrideDisplay, // Override shown
	input wire indicatorGreen, // Green indicator
	input wire muteActive // Muting
);
	localparam longint OvrLimit = 120000 * longint'(TICK_CYCLES) + 16;
	logic [7:0] armHist;
	logic [7:0] bothHist;
	longint ovCnt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ==================================================
	// History windows: a window hides the exact sync latency of the pins
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			armHist <= 8'h00;
			bothHist <= 8'h00;
			ovCnt <= 0;
		end else begin
			armHist <= {armHist[6:0], zoneViolated & (firstMuteSensor | secondMuteSensor)};
			bothHist <= {bothHist[6:0], firstMuteSensor & secondMuteSensor};
			ovCnt <= overrideDisplay ? ovCnt + 1 : 0;
		end
	end
	// ==================================================
	// Bus handshake and override relations
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_error_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside an access cycle");
	a_armed_before_ovr: assert property ($rose(overrideDisplay) |-> armHist != 8'h00)
		else $error("override began while not armed");
	a_ovr_turns_green: assert property ($rose(overrideDisplay) |-> ##[0:2] indicatorGreen)
		else $error("indicator not green after override start");
	a_ovr_time_limit: assert property (ovCnt <= OvrLimit)
		else $error("override outlived its time limit");
	a_clear_ends_ovr: assert property ((!zoneViolated && !firstMuteSensor && !secondMuteSensor)[*6]
		|=> !overrideDisplay) else $error("override kept after clearing");
	a_other_pair_off: assert property (otherZoneViolated[*6] |=>
		!(safetyOutputPairA && safetyOutputPairB)) else $error("blocked pair stayed on");
	a_mute_needs_both: assert property ($rose(muteActive) |-> bothHist != 8'h00)
		else $error("muting began without both sensors");
endmodule // mute_override_sva

bind mute_override_ctrl mute_override_sva #(.TICK_CYCLES(TICK_CYCLES)) mute_override_sva_i (
	.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .firstMuteSensor(firstMuteSensor), .secondMuteSensor(secondMuteSensor),
	.zoneViolated(zoneViolated), .otherZoneViolated(otherZoneViolated),
	.safetyOutputPairA(safetyOutputPairA), .safetyOutputPairB(safetyOutputPairB),
	.overrideDisplay(overrideDisplay), .indicatorGreen(indicatorGreen), .muteActive(muteActive));

// ==== verif/override_partner.sv ====
// Model of the operator override switches and the two mute sensors.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
module override_partner (
	input wire core_clk, // Paces the operator
	output logic bypassIn1, // Override pin 1
	output logic bypassIn2, // Override pin 2
	output logic firstMuteSensor, // Sensor 1, high active
	output logic secondMuteSensor // Sensor 2, high active
);
	// ==================================================
	// Idle levels: pin 1 closed for pulse mode, sensors released
	initial begin
		bypassIn1 = 1'b1;
		bypassIn2 = 1'b1;
		firstMuteSensor = 1'b0;
		secondMuteSensor = 1'b0;
	end
	// Switch wiring differs with the pin count, so the idle level is chosen here
	task idle(input logic two);
		bypassIn1 <= !two;
		bypassIn2 <= 1'b1;
	endtask
	task sense(input logic a, input logic b);
		firstMuteSensor <= a;
		secondMuteSensor <= b;
	endtask
	// Openings of w clocks; callers keep w under one second of ticks
	task pulses(input int n, input int w);
		repeat (n) begin
			bypassIn1 <= 1'b0;
			repeat (w) @(posedge core_clk);
			bypassIn1 <= 1'b1;
			repeat (w) @(posedge core_clk);
		end
	endtask
	// Pin 1 closes, pin 2 opens t clocks later
	task lead(input int t);
		bypassIn1 <= 1'b1;
		repeat (t) @(posedge core_clk);
		bypassIn2 <= 1'b0;
	endtask
endmodule // override_partner

// ==== verif/mute_dependent_override_ctrl_tb_top.sv ====
// Self-checking bench for the override controller with a switch and sensor model.
// Assumes a tick of 10 clocks so that the millisecond figures stay short.
`timescale 1ns/1ps
module mute_dependent_override_ctrl_tb_top;
	localparam int T = 10; // Clocks per tick
	logic core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, lim, v;
	logic bypassIn1, bypassIn2, firstMuteSensor, secondMuteSensor;
	logic zoneViolated, sectionViolated, otherZoneViolated;
	logic safetyOutputPairA, safetyOutputPairB, overrideDisplay, indicatorGreen, muteActive;
	int nErrors = 0;
	int samplesChecked = 0;
	int cycles = 0;
	int leads[3] = '{50, 450, 200};
	mute_override_ctrl #(.TICK_CYCLES(T)) mute_override_ctrl_i (.core_clk(core_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .bypassIn1(bypassIn1),
		.bypassIn2(bypassIn2), .firstMuteSensor(firstMuteSensor),
		.secondMuteSensor(secondMuteSensor), .zoneViolated(zoneViolated),
		.sectionViolated(sectionViolated), .otherZoneViolated(otherZoneViolated),
		.safetyOutputPairA(safetyOutputPairA), .safetyOutputPairB(safetyOutputPairB),
		.overrideDisplay(overrideDisplay), .indicatorGreen(indicatorGreen),
		.muteActive(muteActive));
	override_partner override_partner_i (.core_clk(core_clk), .bypassIn1(bypassIn1),
		.bypassIn2(bypassIn2), .firstMuteSensor(firstMuteSensor),
		.secondMuteSensor(secondMuteSensor));
	// ==================================================
	// Clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// Hang guard: well above the roughly 44k cycles the tests need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 90000) begin
			nErrors++;
			final_report;
		end
	end
	// ==================================================
	// Shared tasks
	task final_report;
		$display("checks %0d mismatches %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nErrors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Request held until pready is seen at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50)
			nErrors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge so a following call never re-raises psel in the same step
		@(posedge core_clk);
	endtask
	// Out-of-range limits are dropped silently, so the old value survives
	function logic [31:0] limExp(input logic [31:0] old, input logic [31:0] nw);
		return (nw == 0 || (nw >= 10 && nw <= 1080)) ? nw : old;
	endfunction
	task twoPin(input int t, input logic e);
		override_partner_i.idle(1'b1);
		cyc(500 * T);
		override_partner_i.lead(t);
		cyc(20);
		check(overrideDisplay, e);
	endtask
	task arm;
		zoneViolated <= 1'b1;
		override_partner_i.sense(1'b1, 1'b0);
	endtask
	// ==================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{zoneViolated, sectionViolated, otherZoneViolated} = 3'h0;
		v = $urandom(23);
		cyc(6);
		rst <= 1'b0;
		cyc(2);
		apb(1'b0, 12'h004, 32'h0);
		check(rd, 32'h0000000A);
		apb(1'b0, 12'h000, 32'h0);
		check(rd, 32'h00000000);
		apb(1'b0, 12'h020, 32'h0);
		check({rd, err}, 33'h000000001);
		lim = 32'h0000000A;
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 32'h00000009 : (i == 1) ? 32'h00000438 : $urandom_range(1200);
			apb(1'b1, 12'h004, v);
			lim = limExp(lim, v);
			apb(1'b0, 12'h004, 32'h0);
			check(rd, lim);
		end
		$display("test registers done");
		override_partner_i.sense(1'b1, 1'b1);
		cyc(20);
		check(muteActive, 1'b1);
		override_partner_i.sense(1'b1, 1'b0);
		cyc(20);
		check(muteActive, 1'b0);
		$display("test muting done");
		zoneViolated <= 1'b1;
		override_partner_i.sense(1'b0, 1'b0);
		override_partner_i.pulses(3, 100 * T);
		cyc(20);
		check(overrideDisplay, 1'b0);
		arm;
		override_partner_i.pulses(3, 100 * T);
		cyc(20);
		check({overrideDisplay, indicatorGreen, safetyOutputPairA}, 3'h7);
		otherZoneViolated <= 1'b1;
		override_partner_i.pulses(1, 50 * T);
		cyc(20);
		check({overrideDisplay, safetyOutputPairA, safetyOutputPairB}, 3'h6);
		zoneViolated <= 1'b0;
		otherZoneViolated <= 1'b0;
		override_partner_i.sense(1'b0, 1'b0);
		cyc(20);
		check(overrideDisplay, 1'b0);
		$display("test pulse pattern done");
		apb(1'b1, 12'h000, 32'h00000005);
		arm;
		twoPin(200 * T, 1'b1);
		override_partner_i.idle(1'b1);
		cyc(20);
		check(overrideDisplay, 1'b0);
		$display("test level pattern done");
		apb(1'b1, 12'h000, 32'h00000006);
		for (int i = 0; i < 3; i++)
			twoPin(leads[i] * T, i == 2);
		override_partner_i.idle(1'b1);
		cyc(20);
		check(overrideDisplay, 1'b1);
		zoneViolated <= 1'b0;
		override_partner_i.sense(1'b0, 1'b0);
		cyc(20);
		check(overrideDisplay, 1'b0);
		$display("test edge pattern done");
		// Unidirectional: tail lasts factor 2 times the 50-tick activation gap
		apb(1'b1, 12'h000, 32'h00000008);
		override_partner_i.sense(1'b1, 1'b0);
		cyc(50 * T);
		override_partner_i.sense(1'b1, 1'b1);
		cyc(20);
		check(muteActive, 1'b1);
		override_partner_i.sense(1'b0, 1'b1);
		cyc(50 * T);
		check(muteActive, 1'b1);
		cyc(60 * T);
		check(muteActive, 1'b0);
		override_partner_i.sense(1'b0, 1'b0);
		$display("test unidirectional muting done");
		final_report;
	end
endmodule // mute_dependent_override_ctrl_tb_top
